// *** include/acs_regs.svh ***
// Purpose: Register map, field positions, reset values and timing counts of the
//          converter sequencer.
// Assumes: 200 MHz bus clock; AXI4-Lite with 8-bit byte addresses.
// Notes:   Each register holds at most 8 bits in byte lane 0; upper bits read as zero.
//
// Notes on behaviour
// (R1) Software mode: write to set A with channel not all ones starts conversion.
// (R2) Hardware mode: trigger edge with a select active starts set A or B.
// (R3) Continuous mode restarts after each transfer until aborted.
// (R4) Averaging restarts conversions until the count; continuous starts a new set.
// (R5) Flag sets on transfer; only after last averaged one; only if compare true.
// (R6) Interrupt raised when flag sets while its enable is high.
// (R7) High byte read, low not yet: new result discarded, flag stays clear; the code does not block in 8-bit single-ended mode.
// (R8) Blocked transfer restarts conversion, except single with compare false.
// (R9) Software reads both bytes quickly, or not before completion.
// (R10) Writing the governing set aborts; only set A starts by software.
// (R11) Any write to another register aborts the conversion.
// (R12) Reset, deep stop, or middle stop without async clock abort.
// (R13) Abort keeps results, except reset and deep stop clear them.
// (R14) Idle until started; async clock runs always when its enable is set.
// (R15) Time is first adder plus factor times base, long sample, high speed.
// (R16) First adder 3 or 5 converter cycles, 5 bus cycles, 5 us startup.
// (R17) Software sets async clock enable 5 us before starting.
// (R18) Average factor 1, or 4, 8, 16, 32 by count select.
// (R19) Base time 17, 27, 20, 30, 25 or 34 converter cycles by mode.
// (R20) Long sample adds 0, or 20, 12, 6, 2 converter cycles.
// (R21) High speed adds 4 converter cycles to every conversion.
// (R22) Sample first, then approximate, then transfer the result.
// (R23) Converter disabled in reset, deep stop, or channel all ones.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ACS_OFF_SC_A 8'h00
`define ACS_OFF_SC_B 8'h04
`define ACS_OFF_CFG1 8'h08
`define ACS_OFF_CFG2 8'h0c
`define ACS_OFF_CFG3 8'h10
`define ACS_OFF_RHA 8'h14
`define ACS_OFF_RLA 8'h18
`define ACS_OFF_RHB 8'h1c
`define ACS_OFF_RLB 8'h20
`define ACS_OFF_STAT 8'h24

// ****************************************
// Field positions
// ****************************************
`define ACS_SC_FLAG 7
`define ACS_SC_IE 6
`define ACS_SC_DIFF 5
`define ACS_C1_LPC 7
`define ACS_C1_DIV 5
`define ACS_C1_LSMP 4
`define ACS_C1_MODE 2
`define ACS_C1_CLKSEL 0
`define ACS_C2_TRGM 5
`define ACS_C2_ACKEN 4
`define ACS_C2_HSC 2
`define ACS_C2_LSTS 0
`define ACS_C3_CMPE 4
`define ACS_C3_CONT 3
`define ACS_C3_AVERAGE_ENABLE 2
`define ACS_C3_AVERAGE_COUNT_SELECT 0

// ****************************************
// Codes and reset values
// ****************************************
`define ACS_CH_OFF 5'h1f
`define ACS_MODE_8B 2'h0
`define ACS_CLK_HALF 2'h1
`define ACS_CLK_ASYNC 2'h3
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

// ****************************************
// Timing counts
// ****************************************
`define ACS_CLK_PERIOD_NS 5
`define ACS_ASYNC_START_NS 5000
`define ACS_START_CYC ((`ACS_ASYNC_START_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_SETUP_BUS 10'h005
`define ACS_SFC_LONG 3'h3
`define ACS_SFC_SHORT 3'h5
`define ACS_BCT_8SE 6'h11
`define ACS_BCT_9DF 6'h1b
`define ACS_BCT_12SE 6'h14
`define ACS_BCT_13DF 6'h1e
`define ACS_BCT_16SE 6'h19
`define ACS_BCT_16DF 6'h22
`define ACS_LST_0 5'h14
`define ACS_LST_1 5'h0c
`define ACS_LST_2 5'h06
`define ACS_LST_3 5'h02
`define ACS_HSC_ADD 6'h04

`endif

// *** include/acs_pkg.sv ***
// Purpose: Types shared by the converter sequencer modules.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   State structs are registered whole by each module.
package acs_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_SAMPLE = 5'b00100,
        ST_CONV = 5'b01000,
        ST_XFER = 5'b10000
    } acs_state_e;

    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } acs_tick_s;

    typedef struct packed {
        acs_state_e st;
        logic [9:0] cnt;
        logic [4:0] syn1;
        logic [4:0] syn2;
        logic trg_q;
        logic set_b;
        logic [4:0] avg_cnt;
        logic [20:0] acc;
        logic [1:0][4:0] chan;
        logic [1:0] diff;
        logic [1:0] ie;
        logic [1:0] flag;
        logic [1:0] hi_rd;
        logic [1:0][15:0] res;
        logic [7:0] cfg1;
        logic [5:0] cfg2;
        logic [4:0] cfg3;
        logic aw_ok;
        logic w_ok;
        logic [7:0] aw_a;
        logic [7:0] w_d;
        logic w_s;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irq;
        logic core_en;
        logic samp;
        logic conv;
        logic async_run;
        logic [4:0] core_ch;
        logic core_diff;
    } acs_main_s;

endpackage

// *** hdl/acs_tick.sv ***
// Purpose: Converter clock tick from the bus clock by the selected divide.
// Assumes: All clock sources are modelled as the bus clock.
// Notes:   Counts only while a conversion runs, so idle costs no toggling.
`timescale 1ns/1ps
module acs_tick
    import acs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic [1:0] i_div,
    input wire logic i_half,
    output logic o_tick
);
    acs_tick_s r, s;
    logic [3:0] lim;

    always_comb begin
        s = r;
        lim = 4'((5'h01 << (3'(i_div) + 3'(i_half))) - 5'h01);
        s.tick = 1'b0;
        if (!i_run) begin
            s.cnt = 4'h0;
        end else if (r.cnt >= lim) begin
            s.cnt = 4'h0;
            s.tick = 1'b1;
        end else begin
            s.cnt = r.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    assign o_tick = r.tick;
endmodule // acs_tick

// *** hdl/acs_time.sv ***
// Purpose: Phase lengths in converter cycles for the selected configuration.
// Assumes: Mode code 0 is 8/9-bit, 1 is 12/13, 2 is 10/11, 3 is 16-bit.
// Notes:   Purely combinational; the sequencer loads these into its counter.
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_time
    import acs_pkg::*;
(
    input wire logic [1:0] i_mode,
    input wire logic i_diff,
    input wire logic i_lsmp,
    input wire logic [1:0] i_lsts,
    input wire logic i_hsc,
    input wire logic i_average_enable,
    input wire logic [1:0] i_average_count_select,
    output logic [2:0] o_sfc,
    output logic [4:0] o_lst,
    output logic [5:0] o_bct,
    output logic [4:0] o_avg_last,
    output logic [2:0] o_shift
);
    always_comb begin
        o_sfc = i_lsmp ? `ACS_SFC_LONG : `ACS_SFC_SHORT; // R16
        case ({i_lsmp, i_lsts}) // R20
            3'h4: o_lst = `ACS_LST_0;
            3'h5: o_lst = `ACS_LST_1;
            3'h6: o_lst = `ACS_LST_2;
            3'h7: o_lst = `ACS_LST_3;
            default: o_lst = 5'h00;
        endcase
        case ({i_diff, i_mode}) // R19
            3'h0: o_bct = `ACS_BCT_8SE;
            3'h3: o_bct = `ACS_BCT_16SE;
            3'h4: o_bct = `ACS_BCT_9DF;
            3'h7: o_bct = `ACS_BCT_16DF;
            3'h5, 3'h6: o_bct = `ACS_BCT_13DF;
            default: o_bct = `ACS_BCT_12SE;
        endcase
        if (i_hsc) begin
            o_bct = o_bct + `ACS_HSC_ADD; // R21
        end
        o_shift = i_average_enable ? 3'(i_average_count_select) + 3'h2 : 3'h0; // R18
        o_avg_last = 5'((6'h01 << o_shift) - 6'h01); // R18
    end
endmodule // acs_time

// *** hdl/acs_sequencer.sv ***
// Purpose: Conversion sequencer with AXI4-Lite registers and two control sets.
// Assumes: Compare verdict and converter data come from logic on this clock.
// Notes:   Pins and stop requests pass a two-stage synchroniser first.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "acs_regs.svh"
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic [7:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [7:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic I_HW_TRIGGER,
    input wire logic I_TRIG_SEL_A,
    input wire logic I_TRIG_SEL_B,
    input wire logic I_STOP_DEEP,
    input wire logic I_STOP_MID,
    input wire logic [15:0] I_CORE_DATA,
    input wire logic I_COMPARE_TRUE,
    output logic O_CORE_ENABLE,
    output logic O_SAMPLE,
    output logic O_CONVERT,
    output logic [4:0] O_CHANNEL,
    output logic O_DIFF,
    output logic O_ASYNC_CLK_RUN,
    output logic O_COMPLETE_IRQ
);
    acs_main_s r, s;
    logic tick, wr, wr_en, map_w, rd, act, abort, sw_go, hw_go;
    logic wr_sc_a, wr_sc_b, wr_other, last, cmp_ok, blocked, cont, akn, trg_edge, sel;
    logic [2:0] sfc, shift;
    logic [4:0] lst, avg_last;
    logic [5:0] base_conversion_time;
    logic [15:0] avg;

    acs_tick u_tick (
        .i_clk(I_SYS_CLK),
        .i_reset_n(I_RESET_N),
        .i_run(r.st != ST_IDLE),
        .i_div(r.cfg1[`ACS_C1_DIV +: 2]),
        .i_half(r.cfg1[`ACS_C1_CLKSEL +: 2] == `ACS_CLK_HALF),
        .o_tick(tick)
    );

    acs_time u_time (
        .i_mode(r.cfg1[`ACS_C1_MODE +: 2]),
        .i_diff(r.diff[r.set_b]),
        .i_lsmp(r.cfg1[`ACS_C1_LSMP]),
        .i_lsts(r.cfg2[`ACS_C2_LSTS +: 2]),
        .i_hsc(r.cfg2[`ACS_C2_HSC]),
        .i_average_enable(r.cfg3[`ACS_C3_AVERAGE_ENABLE]),
        .i_average_count_select(r.cfg3[`ACS_C3_AVERAGE_COUNT_SELECT +: 2]),
        .o_sfc(sfc),
        .o_lst(lst),
        .o_bct(base_conversion_time),
        .o_avg_last(avg_last),
        .o_shift(shift)
    );

    always_comb begin
        s = r;
        // ****************************************
        // Pin synchroniser
        // ****************************************
        s.syn1 = {I_STOP_MID, I_STOP_DEEP, I_TRIG_SEL_B, I_TRIG_SEL_A, I_HW_TRIGGER};
        s.syn2 = r.syn1;
        s.trg_q = r.syn2[0];
        trg_edge = r.syn2[0] & ~r.trg_q;
        akn = r.cfg2[`ACS_C2_ACKEN];
        cont = r.cfg3[`ACS_C3_CONT];
        sel = r.set_b;
        act = (r.st != ST_IDLE);
        abort = 1'b0;
        sw_go = 1'b0;

        // ****************************************
        // AXI4-Lite write side
        // ****************************************
        if (I_AXI_AWVALID && r.awready) begin
            s.aw_ok = 1'b1;
            s.aw_a = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && r.wready) begin
            s.w_ok = 1'b1;
            s.w_d = I_AXI_WDATA[7:0];
            s.w_s = I_AXI_WSTRB[0];
        end
        if (r.bvalid && I_AXI_BREADY) begin
            s.bvalid = 1'b0;
        end
        wr = r.aw_ok && r.w_ok && !r.bvalid;
        map_w = (r.aw_a[1:0] == 2'h0) && (r.aw_a <= `ACS_OFF_STAT);
        if (wr) begin
            s.aw_ok = 1'b0;
            s.w_ok = 1'b0;
            s.bvalid = 1'b1;
            s.bresp = map_w ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
        end
        s.awready = !s.aw_ok && !s.bvalid;
        s.wready = !s.w_ok && !s.bvalid;
        wr_en = wr && map_w && r.w_s;
        wr_sc_a = wr_en && (r.aw_a == `ACS_OFF_SC_A);
        wr_sc_b = wr_en && (r.aw_a == `ACS_OFF_SC_B);
        wr_other = wr_en && !wr_sc_a && !wr_sc_b;

        if (wr_sc_a) begin
            s.ie[0] = r.w_d[`ACS_SC_IE];
            s.diff[0] = r.w_d[`ACS_SC_DIFF];
            s.chan[0] = r.w_d[4:0];
            s.flag[0] = 1'b0;
            abort = act && !r.set_b; // R10
            sw_go = !r.cfg2[`ACS_C2_TRGM] && (r.w_d[4:0] != `ACS_CH_OFF); // R1 R23
        end
        if (wr_sc_b) begin
            s.ie[1] = r.w_d[`ACS_SC_IE];
            s.diff[1] = r.w_d[`ACS_SC_DIFF];
            s.chan[1] = r.w_d[4:0];
            s.flag[1] = 1'b0;
            abort = act && r.set_b; // R10
        end
        if (wr_other) begin
            case (r.aw_a)
                `ACS_OFF_CFG1: s.cfg1 = r.w_d;
                `ACS_OFF_CFG2: s.cfg2 = r.w_d[5:0];
                `ACS_OFF_CFG3: s.cfg3 = r.w_d[4:0];
                default: ;
            endcase
            abort = 1'b1; // R11
        end

        // ****************************************
        // AXI4-Lite read side
        // ****************************************
        rd = I_AXI_ARVALID && r.arready;
        if (r.rvalid && I_AXI_RREADY) begin
            s.rvalid = 1'b0;
        end
        if (rd) begin
            s.rvalid = 1'b1;
            s.rresp = `ACS_RESP_OKAY;
            s.rdata = 32'h0;
            case (I_AXI_ARADDR)
                `ACS_OFF_SC_A: s.rdata[7:0] = {r.flag[0], r.ie[0], r.diff[0], r.chan[0]};
                `ACS_OFF_SC_B: s.rdata[7:0] = {r.flag[1], r.ie[1], r.diff[1], r.chan[1]};
                `ACS_OFF_CFG1: s.rdata[7:0] = r.cfg1;
                `ACS_OFF_CFG2: s.rdata[5:0] = r.cfg2;
                `ACS_OFF_CFG3: s.rdata[4:0] = r.cfg3;
                `ACS_OFF_RHA: begin
                    s.rdata[7:0] = r.res[0][15:8];
                    s.hi_rd[0] = 1'b1;
                end
                `ACS_OFF_RLA: begin
                    s.rdata[7:0] = r.res[0][7:0];
                    s.hi_rd[0] = 1'b0;
                    s.flag[0] = 1'b0;
                end
                `ACS_OFF_RHB: begin
                    s.rdata[7:0] = r.res[1][15:8];
                    s.hi_rd[1] = 1'b1;
                end
                `ACS_OFF_RLB: begin
                    s.rdata[7:0] = r.res[1][7:0];
                    s.hi_rd[1] = 1'b0;
                    s.flag[1] = 1'b0;
                end
                `ACS_OFF_STAT: s.rdata[1:0] = {r.async_run, act};
                default: s.rresp = `ACS_RESP_SLVERR;
            endcase
        end
        s.arready = !s.rvalid;

        // ****************************************
        // Conversion sequencer
        // ****************************************
        // A trigger edge while busy is dropped, and set A wins if both selects are up.
        hw_go = r.cfg2[`ACS_C2_TRGM] && !act && trg_edge && (r.syn2[1] || r.syn2[2])
            && (r.chan[!r.syn2[1]] != `ACS_CH_OFF); // R2 R23
        if (r.syn2[4] && !akn) begin
            abort = 1'b1; // R12
        end
        last = (r.avg_cnt == avg_last);
        avg = 16'(r.acc >> shift);
        cmp_ok = !r.cfg3[`ACS_C3_CMPE] || I_COMPARE_TRUE;
        blocked = r.hi_rd[sel]
            && !(r.cfg1[`ACS_C1_MODE +: 2] == `ACS_MODE_8B && !r.diff[sel]); // R7

        case (r.st)
            ST_IDLE: ;
            ST_SETUP: begin
                if (r.cnt <= 10'h001) begin
                    s.st = ST_SAMPLE; // R22
                    s.cnt = 10'(sfc) + 10'(lst); // R15 R16
                end else begin
                    s.cnt = r.cnt - 10'h001;
                end
            end
            ST_SAMPLE: begin
                if (r.cnt == 10'h000) begin
                    s.st = ST_CONV; // R22
                    s.cnt = 10'(base_conversion_time); // R15
                end else if (tick) begin
                    s.cnt = r.cnt - 10'h001;
                end
            end
            ST_CONV: begin
                if (r.cnt == 10'h000) begin
                    s.st = ST_XFER;
                    s.acc = r.acc + 21'(I_CORE_DATA);
                end else if (tick) begin
                    s.cnt = r.cnt - 10'h001;
                end
            end
            ST_XFER: begin
                s.st = ST_SAMPLE;
                s.cnt = 10'(lst);
                if (!last) begin
                    s.avg_cnt = r.avg_cnt + 5'h01; // R4
                end else begin
                    s.acc = 21'h0;
                    s.avg_cnt = 5'h00;
                    if (!cmp_ok) begin
                        s.st = cont ? ST_SAMPLE : ST_IDLE; // R5 R8
                    end else if (!blocked) begin
                        s.res[sel] = avg; // R5 R22
                        s.flag[sel] = 1'b1; // R5
                        s.st = cont ? ST_SAMPLE : ST_IDLE; // R3 R4
                    end
                    // A blocked transfer falls through to a fresh conversion.
                end
            end
            default: s.st = ST_IDLE;
        endcase

        if (abort) begin
            s.st = ST_IDLE; // R10 R11 R12 R13
        end
        if (sw_go || hw_go) begin
            s.st = ST_SETUP; // R1 R2
            s.set_b = hw_go && !r.syn2[1];
            s.acc = 21'h0;
            s.avg_cnt = 5'h00;
            s.cnt = `ACS_SETUP_BUS; // R16
            if (r.cfg1[`ACS_C1_CLKSEL +: 2] == `ACS_CLK_ASYNC && !akn) begin
                s.cnt = `ACS_SETUP_BUS + 10'(`ACS_START_CYC); // R16
            end
        end
        if (r.syn2[3]) begin
            s.st = ST_IDLE; // R12
            s.res = '0; // R13
            s.hi_rd = 2'h0;
        end

        // ****************************************
        // Registered outputs
        // ****************************************
        s.irq = |(s.flag & s.ie); // R6
        s.core_en = (s.st != ST_IDLE) && !r.syn2[3]; // R14 R23
        s.samp = (s.st == ST_SAMPLE);
        s.conv = (s.st == ST_CONV);
        s.core_ch = s.chan[s.set_b];
        s.core_diff = s.diff[s.set_b];
        s.async_run = s.cfg2[`ACS_C2_ACKEN]
            || ((s.st != ST_IDLE) && s.cfg1[`ACS_C1_CLKSEL +: 2] == `ACS_CLK_ASYNC); // R14
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            r <= '0; // R12 R13
            r.st <= ST_IDLE;
            r.chan <= {2{`ACS_CH_OFF}};
        end else begin
            r <= s;
        end
    end

    assign O_AXI_AWREADY = r.awready;
    assign O_AXI_WREADY = r.wready;
    assign O_AXI_BRESP = r.bresp;
    assign O_AXI_BVALID = r.bvalid;
    assign O_AXI_ARREADY = r.arready;
    assign O_AXI_RDATA = r.rdata;
    assign O_AXI_RRESP = r.rresp;
    assign O_AXI_RVALID = r.rvalid;
    assign O_CORE_ENABLE = r.core_en;
    assign O_SAMPLE = r.samp;
    assign O_CONVERT = r.conv;
    assign O_CHANNEL = r.core_ch;
    assign O_DIFF = r.core_diff;
    assign O_ASYNC_CLK_RUN = r.async_run;
    assign O_COMPLETE_IRQ = r.irq;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_sw_start: assert property ( // R1
        sw_go && !r.syn2[3] |=> r.st == ST_SETUP && !r.set_b)
        else $error("Software write did not start set A.");
    a_hw_start: assert property ( // R2
        hw_go && !r.syn2[3] && !abort |=> r.st == ST_SETUP && r.set_b == $past(!r.syn2[1]))
        else $error("Hardware trigger did not start the chosen set.");
    a_flag_xfer: assert property ( // R5
        r.st == ST_XFER && last && cmp_ok && !blocked && !r.syn2[3]
        |=> r.flag[$past(sel)] && r.res[$past(sel)] == $past(avg))
        else $error("Completed result not transferred with flag.");
    a_irq_flag: assert property ( // R6
        $rose(r.flag[0]) && r.ie[0] |-> O_COMPLETE_IRQ)
        else $error("Interrupt missing when flag set.");
    a_block_drop: assert property ( // R7
        r.st == ST_XFER && last && cmp_ok && blocked && !abort && !sw_go && !r.syn2[3]
        |=> $stable(r.res) && r.st == ST_SAMPLE)
        else $error("Blocked result not discarded and restarted.");
    a_cfg_abort: assert property ( // R11
        wr_other && !r.syn2[3] |=> r.st == ST_IDLE)
        else $error("Configuration write did not abort.");
    a_deep_stop: assert property ( // R13
        r.syn2[3] |=> r.st == ST_IDLE && r.res == '0 && !O_CORE_ENABLE)
        else $error("Deep stop did not clear results.");
    a_async_run: assert property ( // R14
        r.cfg2[`ACS_C2_ACKEN] |-> O_ASYNC_CLK_RUN)
        else $error("Async clock stopped while enabled.");
    a_setup_len: assert property ( // R16
        sw_go && !r.syn2[3] && r.cfg1[`ACS_C1_CLKSEL +: 2] != `ACS_CLK_ASYNC
        |=> (r.st == ST_SETUP && !wr_en && !r.syn2[3])[*5] ##1 r.st == ST_SAMPLE)
        else $error("First adder bus cycles wrong.");
    a_avg_step: assert property ( // R4
        r.st == ST_XFER && !last && !abort && !sw_go && !r.syn2[3]
        |=> r.st == ST_SAMPLE && $stable(r.flag) && r.avg_cnt == $past(r.avg_cnt) + 5'h01)
        else $error("Averaging step misbehaved.");

    c_sw_done: cover property (r.st == ST_XFER ##1 $rose(r.flag[0]));
    c_hw_b: cover property (hw_go && r.syn2[2] && !r.syn2[1]);
    c_blocked: cover property (r.st == ST_XFER && last && blocked);
    c_avg_cont: cover property (r.st == ST_XFER && last && cont && r.cfg3[`ACS_C3_AVERAGE_ENABLE]);
endmodule // acs_sequencer

// *** tb/acs_core_model.sv ***
// Purpose: Converter core stand-in that returns a word per conversion.
// Assumes: Data is sampled on the last approximation cycle.
// Notes: Outside conversion the data lines toggle so stale words never match.
`timescale 1ns/1ps
module acs_core_model (
    input wire logic i_clk,
    input wire logic i_convert,
    output logic [15:0] o_data,
    output logic o_compare_true
);
    initial o_data = 16'h0000;
    initial o_compare_true = 1'b1;
    always @(posedge i_clk) begin
        if (i_convert) begin
            o_data <= 16'($urandom);
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule // acs_core_model

// *** tb/test_adc_conversion_sequencer.sv ***
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Compare is off, so the verdict line only needs a legal level.
// Notes: Reads queue their expectation; a monitor checks each read beat.
`timescale 1ns/1ps
`include "acs_regs.svh"
module test_adc_conversion_sequencer;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic trg = 0, sel_b = 0, awr, wrdy, bv, arr, rv, en, irq, conv, cmp, arun, odiff, samp;
    logic [4:0] och;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] rresp;
    logic [15:0] cdata, last_d;
    logic [34:0] q[$];
    int n_fail = 0, check_count = 0;
    always #2.5 clk = ~clk;
    acs_sequencer dut_u (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_AXI_AWADDR(awaddr),
        .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hf),
        .I_AXI_WVALID(wv), .O_AXI_WREADY(wrdy), .O_AXI_BRESP(), .O_AXI_BVALID(bv),
        .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv),
        .I_AXI_RREADY(rready), .I_HW_TRIGGER(trg), .I_TRIG_SEL_A(1'b0), .I_TRIG_SEL_B(sel_b),
        .I_STOP_DEEP(1'b0), .I_STOP_MID(1'b0), .I_CORE_DATA(cdata), .I_COMPARE_TRUE(cmp),
        .O_CORE_ENABLE(en), .O_SAMPLE(samp), .O_CONVERT(conv), .O_CHANNEL(och), .O_DIFF(odiff),
        .O_ASYNC_CLK_RUN(arun), .O_COMPLETE_IRQ(irq));
    acs_core_model core_u (.i_clk(clk), .i_convert(conv), .o_data(cdata),
        .o_compare_true(cmp));
    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic fail(input string m);
        n_fail++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) fail("pin level");
    endtask
    task automatic chk_rd(input logic [1:0] r, input logic [31:0] d, input logic [34:0] e);
        check_count++;
        if (r !== e[33:32] || (e[34] && d !== e[31:0])) fail("read beat");
    endtask
    always @(posedge clk) begin
        if (rv && rready) chk_rd(rresp, rdata, q.pop_front());
        if (conv) last_d <= cdata;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awv <= 1; wv <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
        end while (!bv);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [34:0] e);
        @(posedge clk);
        q.push_back(e); araddr <= a; arv <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!rv);
        rready <= 0;
    endtask
    // The wait is bounded so that a stuck sequencer still reaches the verdict.
    task automatic idle;
        int t = 0;
        repeat (3) @(posedge clk);
        while (en && t < 3000) begin
            @(posedge clk);
            t++;
        end
        if (en) fail("idle timeout");
    endtask
    task automatic results;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [4:0] ch;
        ch = 5'($urandom(32'h60d2) % 31);
        repeat (12) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 32'h1f});
        rd(8'h28, {1'b0, 2'h2, 32'h0});
        wr(`ACS_OFF_SC_A, 8'h1f);
        repeat (6) @(posedge clk);
        chk_pin(en, 1'b0);
        chk_pin(arun, 1'b0);
        wr(`ACS_OFF_SC_A, {3'b010, ch});
        idle;
        chk_pin(irq, 1'b1);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b110, ch});
        rd(`ACS_OFF_RHA, {1'b1, 2'h0, 24'h0, last_d[15:8]});
        rd(`ACS_OFF_RLA, {1'b1, 2'h0, 24'h0, last_d[7:0]});
        repeat (2) @(posedge clk);
        chk_pin(irq, 1'b0);
        wr(`ACS_OFF_CFG1, 8'h04);
        rd(`ACS_OFF_RHA, {1'b0, 2'h0, 32'h0});
        wr(`ACS_OFF_SC_A, {3'b000, ch});
        repeat (150) @(posedge clk);
        chk_pin(en, 1'b1);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b000, ch});
        rd(`ACS_OFF_RLA, {1'b0, 2'h0, 32'h0});
        idle;
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b100, ch});
        wr(`ACS_OFF_SC_A, {3'b000, ch});
        repeat (8) @(posedge clk);
        wr(`ACS_OFF_CFG3, 8'h00);
        repeat (3) @(posedge clk);
        chk_pin(en, 1'b0);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b000, ch});
        wr(`ACS_OFF_CFG3, 8'h0c);
        wr(`ACS_OFF_SC_A, {3'b000, ch});
        repeat (60) @(posedge clk);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b000, ch});
        repeat (140) @(posedge clk);
        chk_pin(en, 1'b1);
        rd(`ACS_OFF_SC_A, {1'b1, 2'h0, 24'h0, 3'b100, ch});
        wr(`ACS_OFF_SC_A, 8'h1f);
        repeat (3) @(posedge clk);
        chk_pin(en, 1'b0);
        wr(`ACS_OFF_CFG3, 8'h00);
        wr(`ACS_OFF_CFG1, 8'h07);
        wr(`ACS_OFF_CFG2, 8'h30);
        wr(`ACS_OFF_SC_B, 8'h25);
        sel_b <= 1;
        repeat (1000) @(posedge clk);
        chk_pin(arun, 1'b1);
        trg <= 1;
        repeat (4) @(posedge clk);
        trg <= 0;
        chk_pin({odiff, och}, 8'h25);
        repeat (6) @(posedge clk);
        chk_pin(samp, 1'b1);
        idle;
        rd(`ACS_OFF_SC_B, {1'b1, 2'h0, 32'ha5});
        results;
    end
    initial begin
        #100000;
        fail("watchdog");
        results;
    end
endmodule // test_adc_conversion_sequencer
